// ===== core/adc_trig_pkg.sv
// Register map, field positions, reset values and trigger codes of the
// converter control block.
// Assumes a 32-bit APB slave port with one aligned word per register.
package adc_trig_pkg;

	// ----------------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------------
	localparam logic [7:0] OFS_CONV_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CONV_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_INPUT_MUX = 8'h08;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h0c;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
	localparam logic [7:0] OFS_PIN_DIS_0 = 8'h14;
	localparam logic [7:0] OFS_PIN_DIS_1 = 8'h18;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int CA_ENABLE = 7;
	localparam int CA_START_CONV = 6;
	localparam int CA_AUTO_TRIGGER_EN = 5;
	localparam int CA_DONE_FLAG = 4;
	localparam int CA_DONE_IRQ_EN = 3;
	localparam int CB_HIGH_SPEED_SEL = 7;
	localparam int CB_AMP_CONV_REQUEST = 4;
	localparam int MUX_LEFT_ADJUST = 5;

	// ----------------------------------------------------------------------
	// Reset values and widths
	// ----------------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_RESULT = 10'h000;
	localparam int DIS1_WIDTH = 6;

	// ----------------------------------------------------------------------
	// Trigger source codes and amplified channel codes
	// ----------------------------------------------------------------------
	localparam logic [3:0] TRIG_FREE_RUN = 4'h0;
	localparam logic [3:0] TRIG_SYNC0 = 4'h8;
	localparam logic [3:0] TRIG_SYNC2 = 4'ha;
	localparam logic [3:0] TRIG_CMP1 = 4'hb;
	localparam logic [3:0] TRIG_CMP2 = 4'hc;
	localparam logic [3:0] CHAN_AMP0 = 4'hb;
	localparam logic [3:0] CHAN_AMP1 = 4'hc;
	localparam int NUM_TRIG_FLAGS = 9;

endpackage : adc_trig_pkg

// ===== core/adc_trigger_select.sv
// Auto-trigger edge and sync event detector.
// Assumes flags and sync events come from logic on the same clock.
`timescale 1ns/1ps
module adc_trigger_select #(
	parameter int NUM_FLAGS = adc_trig_pkg::NUM_TRIG_FLAGS
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [NUM_FLAGS-1:0] flags,
	input wire logic [2:0] sync_evt,
	input wire logic [3:0] trig_sel,
	input wire logic auto_en,
	input wire logic amplified,
	input wire logic idle,
	output logic fire
);
	import adc_trig_pkg::*;

	if (NUM_FLAGS != NUM_TRIG_FLAGS)
	begin : g_bad_flag_count
		$error("trigger flag count must match the decode table");
	end

	// ----------------------------------------------------------------------
	// Decode of flag sources
	// ----------------------------------------------------------------------
	function automatic logic pick_flag(input logic [3:0] code,
		input logic [NUM_FLAGS-1:0] f);
		logic r;
		r = 1'b0;
		if (code >= 4'h1 && code <= 4'h7)
			r = f[code - 4'h1];
		else if (code == TRIG_CMP1)
			r = f[7];
		else if (code == TRIG_CMP2)
			r = f[8];
		return r;
	endfunction : pick_flag

	logic cur_flag;
	logic prev_flag_ff;
	logic is_sync;
	logic sync_hit;

	assign cur_flag = pick_flag(trig_sel, flags);
	assign is_sync = trig_sel >= TRIG_SYNC0 && trig_sel <= TRIG_SYNC2;
	assign sync_hit = is_sync && sync_evt[trig_sel[1:0]];

	// ----------------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
			prev_flag_ff <= 1'b0;
		else
			prev_flag_ff <= cur_flag;
	end

	// Amplified conversions accept only sync sources; flag codes are void.
	always_comb
	begin
		fire = 1'b0;
		if (auto_en)
		begin
			if (sync_hit && idle)
				fire = 1'b1;
			else if (!amplified && cur_flag && !prev_flag_ff)
				fire = 1'b1;
		end
	end

endmodule : adc_trigger_select

// ===== core/adc_result_store.sv
// Locked two-byte result store with left or right presentation.
// Assumes read strobes are single-cycle and on the same clock.
`timescale 1ns/1ps
module adc_result_store (
	input wire logic clk,
	input wire logic rstn,
	input wire logic done,
	input wire logic [9:0] result,
	input wire logic left_adjust,
	input wire logic rd_low,
	input wire logic rd_high,
	output logic [7:0] high_byte,
	output logic [7:0] low_byte,
	output logic locked
);
	import adc_trig_pkg::*;

	logic [9:0] value_ff;
	logic lock_ff;

	always_ff @(posedge clk)
	begin
		if (!rstn)
			value_ff <= RST_RESULT;
		else if (done && !lock_ff && !rd_low)
			value_ff <= result;
	end

	// A low read holds both bytes until the high byte has been taken.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			lock_ff <= 1'b0;
		else if (rd_high)
			lock_ff <= 1'b0;
		else if (rd_low)
			lock_ff <= 1'b1;
	end

	// Presentation is combinational so the adjust bit acts at once.
	always_comb
	begin
		if (left_adjust)
		begin
			high_byte = value_ff[9:2];
			low_byte = {value_ff[1:0], 6'h00};
		end
		else
		begin
			high_byte = {6'h00, value_ff[9:8]};
			low_byte = value_ff[7:0];
		end
	end

	assign locked = lock_ff;

endmodule : adc_result_store

// ===== core/adc_trigger_and_result_regs.sv
// Converter control: trigger selection, conversion start, locked results
// and digital input buffer disables, reached over APB.
// Assumes the analog core answers each start with one done pulse and a
// 10-bit result, and that trigger flags are on this clock.
`timescale 1ns/1ps
module adc_trigger_and_result_regs #(
	parameter bit AMP_REQ_PRESENT = 1'b1
)(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [adc_trig_pkg::NUM_TRIG_FLAGS-1:0] TRIG_FLAGS,
	input wire logic [2:0] SYNC_EVT,
	input wire logic AMP_CLK_EVT,
	input wire logic CONV_DONE,
	input wire logic [9:0] CONV_RESULT,
	input wire logic IRQ_VECTOR_ACK,
	input wire logic [7:0] PIN_RAW_LOW,
	input wire logic [adc_trig_pkg::DIS1_WIDTH-1:0] PIN_RAW_HIGH,
	output logic CONV_START,
	output logic CONV_ENABLE,
	output logic HIGH_SPEED_MODE,
	output logic [2:0] CLK_DIV_SEL,
	output logic [7:0] INPUT_MUX_OUT,
	output logic CONV_IRQ_REQ,
	output logic [7:0] ANALOG_PIN_BUF_OFF_LOW,
	output logic [adc_trig_pkg::DIS1_WIDTH-1:0] PIN_BUF_OFF_HIGH,
	output logic [7:0] PIN_READ_LOW,
	output logic [adc_trig_pkg::DIS1_WIDTH-1:0] PIN_READ_HIGH
);
	import adc_trig_pkg::*;

	// ----------------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------------
	logic [7:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [7:0] mux_ff;
	logic [7:0] dis0_ff;
	logic [DIS1_WIDTH-1:0] dis1_ff;
	logic busy_ff;
	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic start_ff;
	logic irq_ff;
	logic [7:0] raw_low_meta_ff;
	logic [7:0] raw_low_ff;
	logic [DIS1_WIDTH-1:0] raw_high_meta_ff;
	logic [DIS1_WIDTH-1:0] raw_high_ff;
	logic [7:0] pin_low_ff;
	logic [DIS1_WIDTH-1:0] pin_high_ff;

	// ----------------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		return a == OFS_CONV_CTRL_A || a == OFS_CONV_CTRL_B ||
			a == OFS_INPUT_MUX || a == OFS_RESULT_LOW ||
			a == OFS_RESULT_HIGH || a == OFS_PIN_DIS_0 ||
			a == OFS_PIN_DIS_1;
	endfunction : mapped

	logic access_done;
	logic take;
	logic wr;
	logic rd;

	// Writes land on the last access cycle; reads lock on the first.
	assign access_done = PSEL && PENABLE && pready_ff;
	assign take = PSEL && PENABLE && !pready_ff;
	assign wr = access_done && PWRITE && PSTRB[0] && mapped(PADDR);
	assign rd = take && !PWRITE;

	function automatic logic wr_to(input logic [7:0] a);
		return wr && PADDR == a;
	endfunction : wr_to

	// ----------------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------------
	logic amplified;
	logic auto_en;
	logic idle;
	logic fire;
	logic launch;
	logic free_restart;
	logic amp_grant;
	logic [7:0] high_byte;
	logic [7:0] low_byte;

	assign amplified = mux_ff[3:0] == CHAN_AMP0 || mux_ff[3:0] == CHAN_AMP1;
	assign auto_en = ctrl_a_ff[CA_AUTO_TRIGGER_EN];
	assign idle = !busy_ff && !ctrl_a_ff[CA_START_CONV];
	assign launch = ctrl_a_ff[CA_START_CONV] && !busy_ff &&
		ctrl_a_ff[CA_ENABLE];
	// Free running restarts plain conversions only; amplified ones need
	// software to set the start bit again.
	assign free_restart = CONV_DONE && auto_en && !amplified &&
		ctrl_b_ff[3:0] == TRIG_FREE_RUN;
	assign amp_grant = AMP_REQ_PRESENT && ctrl_b_ff[CB_AMP_CONV_REQUEST] &&
		AMP_CLK_EVT && idle;

	adc_trigger_select #(
		.NUM_FLAGS(NUM_TRIG_FLAGS)
	) u_trig (
		.clk(CLOCK),
		.rstn(RSTN),
		.flags(TRIG_FLAGS),
		.sync_evt(SYNC_EVT),
		.trig_sel(ctrl_b_ff[3:0]),
		.auto_en(auto_en),
		.amplified(amplified),
		.idle(idle),
		.fire(fire)
	);

	adc_result_store u_result (
		.clk(CLOCK),
		.rstn(RSTN),
		.done(CONV_DONE && busy_ff),
		.result(CONV_RESULT),
		.left_adjust(mux_ff[MUX_LEFT_ADJUST]),
		.rd_low(rd && PADDR == OFS_RESULT_LOW),
		.rd_high(rd && PADDR == OFS_RESULT_HIGH),
		.high_byte(high_byte),
		.low_byte(low_byte),
		.locked()
	);

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			busy_ff <= 1'b0;
		else if (launch)
			busy_ff <= 1'b1;
		else if (CONV_DONE)
			busy_ff <= 1'b0;
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			start_ff <= 1'b0;
		else
			start_ff <= launch;
	end

	// ----------------------------------------------------------------------
	// Control register A
	// ----------------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			ctrl_a_ff <= RST_BYTE;
		else
		begin
			if (wr_to(OFS_CONV_CTRL_A))
			begin
				ctrl_a_ff[7] <= PWDATA[7];
				ctrl_a_ff[5] <= PWDATA[5];
				ctrl_a_ff[3:0] <= PWDATA[3:0];
			end
			// Start bit: writing zero has no effect; completion clears it.
			if ((wr_to(OFS_CONV_CTRL_A) && PWDATA[CA_START_CONV]) || fire ||
				amp_grant || free_restart)
				ctrl_a_ff[CA_START_CONV] <= 1'b1;
			else if (CONV_DONE && busy_ff)
				ctrl_a_ff[CA_START_CONV] <= 1'b0;
			// Done flag: a completion in the clearing cycle wins.
			if (CONV_DONE && busy_ff)
				ctrl_a_ff[CA_DONE_FLAG] <= 1'b1;
			else if ((wr_to(OFS_CONV_CTRL_A) && PWDATA[CA_DONE_FLAG]) ||
				IRQ_VECTOR_ACK)
				ctrl_a_ff[CA_DONE_FLAG] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Control register B
	// ----------------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			ctrl_b_ff <= RST_BYTE;
		else
		begin
			if (wr_to(OFS_CONV_CTRL_B))
			begin
				ctrl_b_ff[CB_HIGH_SPEED_SEL] <= PWDATA[CB_HIGH_SPEED_SEL];
				ctrl_b_ff[3:0] <= PWDATA[3:0];
				// Software write beats the hardware clear in the same cycle.
				ctrl_b_ff[CB_AMP_CONV_REQUEST] <= AMP_REQ_PRESENT &&
					PWDATA[CB_AMP_CONV_REQUEST];
			end
			else if (amp_grant)
				ctrl_b_ff[CB_AMP_CONV_REQUEST] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Multiplexer and input disable registers
	// ----------------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			mux_ff <= RST_BYTE;
		else if (wr_to(OFS_INPUT_MUX))
			mux_ff <= {PWDATA[7:5], 1'b0, PWDATA[3:0]};
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			dis0_ff <= RST_BYTE;
			dis1_ff <= RST_BYTE[DIS1_WIDTH-1:0];
		end
		else
		begin
			if (wr_to(OFS_PIN_DIS_0))
				dis0_ff <= PWDATA[7:0];
			if (wr_to(OFS_PIN_DIS_1))
				dis1_ff <= PWDATA[DIS1_WIDTH-1:0];
		end
	end

	// Pad levels are asynchronous, so they pass two flops before masking.
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			raw_low_meta_ff <= RST_BYTE;
			raw_low_ff <= RST_BYTE;
			raw_high_meta_ff <= RST_BYTE[DIS1_WIDTH-1:0];
			raw_high_ff <= RST_BYTE[DIS1_WIDTH-1:0];
			pin_low_ff <= RST_BYTE;
			pin_high_ff <= RST_BYTE[DIS1_WIDTH-1:0];
		end
		else
		begin
			raw_low_meta_ff <= PIN_RAW_LOW;
			raw_low_ff <= raw_low_meta_ff;
			raw_high_meta_ff <= PIN_RAW_HIGH;
			raw_high_ff <= raw_high_meta_ff;
			pin_low_ff <= raw_low_ff & ~dis0_ff;
			pin_high_ff <= raw_high_ff & ~dis1_ff;
		end
	end

	// ----------------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [7:0] a);
		logic [7:0] r;
		unique case (a)
			OFS_CONV_CTRL_A: r = ctrl_a_ff;
			OFS_CONV_CTRL_B: r = ctrl_b_ff;
			OFS_INPUT_MUX: r = mux_ff;
			OFS_RESULT_LOW: r = low_byte;
			OFS_RESULT_HIGH: r = high_byte;
			OFS_PIN_DIS_0: r = dis0_ff;
			OFS_PIN_DIS_1: r = {2'h0, dis1_ff};
			default: r = 8'h00;
		endcase
		return r;
	endfunction : read_mux

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= take;
			prdata_ff <= (take && !PWRITE) ?
				{24'h00_0000, read_mux(PADDR)} : 32'h0000_0000;
			pslverr_ff <= take && !mapped(PADDR);
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			irq_ff <= 1'b0;
		else
			irq_ff <= ctrl_a_ff[CA_DONE_FLAG] && ctrl_a_ff[CA_DONE_IRQ_EN];
	end

	assign PRDATA = prdata_ff;
	assign PREADY = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign CONV_START = start_ff;
	assign CONV_ENABLE = ctrl_a_ff[CA_ENABLE];
	assign HIGH_SPEED_MODE = ctrl_b_ff[CB_HIGH_SPEED_SEL];
	assign CLK_DIV_SEL = ctrl_a_ff[2:0];
	assign INPUT_MUX_OUT = mux_ff;
	assign CONV_IRQ_REQ = irq_ff;
	assign ANALOG_PIN_BUF_OFF_LOW = dis0_ff;
	assign PIN_BUF_OFF_HIGH = dis1_ff;
	assign PIN_READ_LOW = pin_low_ff;
	assign PIN_READ_HIGH = pin_high_ff;

endmodule : adc_trigger_and_result_regs

// ===== sim/adc_trig_props.sv
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound to the top module, one clock, sync active-low reset.
`timescale 1ns/1ps
module adc_trig_props (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic PREADY,
	input wire logic CONV_START,
	input wire logic CONV_DONE,
	input wire logic HIGH_SPEED_MODE,
	input wire logic [7:0] ANALOG_PIN_BUF_OFF_LOW,
	input wire logic [adc_trig_pkg::DIS1_WIDTH-1:0] PIN_BUF_OFF_HIGH,
	input wire logic [7:0] PIN_READ_LOW,
	input wire logic [adc_trig_pkg::DIS1_WIDTH-1:0] PIN_READ_HIGH
);
	import adc_trig_pkg::*;
	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	logic busy_ff;
	logic wr_ok;
	assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
			busy_ff <= 1'b0;
		else if (CONV_START)
			busy_ff <= 1'b1;
		else if (CONV_DONE)
			busy_ff <= 1'b0;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		PSEL && PENABLE && !PREADY ##1 PREADY;
	endsequence
	sequence s_start_wr;
		wr_ok && PADDR == OFS_CONV_CTRL_A && PWDATA[7:6] == 2'b11
			&& !busy_ff && !CONV_START;
	endsequence
	// ----------------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------------
	a_ready_timing: assert property (s_setup |=> s_access)
		else $error("answer not in second access cycle");
	a_start_write: assert property (s_start_wr |-> ##[1:2] CONV_START)
		else $error("start write launched nothing");
	a_start_busy: assert property (
		busy_ff && !CONV_DONE |-> !CONV_START)
		else $error("launch while busy");
	a_high_speed: assert property (
		wr_ok && PADDR == OFS_CONV_CTRL_B |=>
		HIGH_SPEED_MODE == $past(PWDATA[CB_HIGH_SPEED_SEL]))
		else $error("high speed mode wrong");
	a_buf_low: assert property (
		wr_ok && PADDR == OFS_PIN_DIS_0 |=>
		ANALOG_PIN_BUF_OFF_LOW == $past(PWDATA[7:0]))
		else $error("low buffer disables wrong");
	a_buf_high: assert property (
		wr_ok && PADDR == OFS_PIN_DIS_1 |=>
		PIN_BUF_OFF_HIGH == $past(PWDATA[DIS1_WIDTH-1:0]))
		else $error("high buffer disables wrong");
	a_mask_low: assert property (
		(PIN_READ_LOW & $past(ANALOG_PIN_BUF_OFF_LOW)) == 8'h00)
		else $error("disabled low pin reads one");
	a_mask_high: assert property (
		(PIN_READ_HIGH & $past(PIN_BUF_OFF_HIGH)) == 6'h00)
		else $error("disabled high pin reads one");
endmodule : adc_trig_props

bind adc_trigger_and_result_regs adc_trig_props adc_trig_props_inst (
	.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.PREADY(PREADY), .CONV_START(CONV_START), .CONV_DONE(CONV_DONE),
	.HIGH_SPEED_MODE(HIGH_SPEED_MODE),
	.ANALOG_PIN_BUF_OFF_LOW(ANALOG_PIN_BUF_OFF_LOW),
	.PIN_BUF_OFF_HIGH(PIN_BUF_OFF_HIGH), .PIN_READ_LOW(PIN_READ_LOW),
	.PIN_READ_HIGH(PIN_READ_HIGH));

// ===== sim/conv_core_model.sv
// Analog core stand-in: answers each launch with one done pulse.
// Assumes launch pulses arrive on the system clock, one at a time.
`timescale 1ns/1ps
module conv_core_model (
	input wire logic clk,
	input wire logic start,
	input wire logic slow,
	output logic done,
	output logic [9:0] result,
	output logic [9:0] last_res
);
	int seed = 32'h0c5f7173;
	logic [9:0] v;
	initial
	begin
		done = 1'b0;
		result = 10'h000;
		last_res = 10'h000;
		forever
		begin
			@(posedge clk);
			if (start === 1'b1)
			begin
				repeat (slow ? 20 : 2) @(posedge clk);
				v = 10'($random(seed));
				done <= 1'b1;
				result <= v;
				last_res <= v;
				@(posedge clk);
				done <= 1'b0;
				// A stale value must not look valid after the pulse.
				result <= ~v;
			end
		end
	end
endmodule : conv_core_model

// ===== sim/test_adc_trigger_and_result_regs.sv
// Self-checking bench for the converter control block.
// Assumes the design package and the analog core stand-in are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
	end end
module test_adc_trigger_and_result_regs;
	import adc_trig_pkg::*;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr, slow;
	logic [7:0] paddr, pin_raw_low, buf_low, read_low, mux_out, d0;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0] pstrb;
	logic [8:0] trig_flags;
	logic [2:0] sync_evt, div_sel;
	logic [5:0] pin_raw_high, buf_high, read_high, d1;
	logic [9:0] conv_result, res;
	logic amp_clk_evt, conv_done, irq_ack, conv_start, en, hsm, irq, l, rerr;
	int seed = 32'h0c5f7173;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_starts = 0;
	int n_base = 0;
	adc_trigger_and_result_regs adc_trigger_and_result_regs_inst (
		.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TRIG_FLAGS(trig_flags), .SYNC_EVT(sync_evt),
		.AMP_CLK_EVT(amp_clk_evt), .CONV_DONE(conv_done),
		.CONV_RESULT(conv_result), .IRQ_VECTOR_ACK(irq_ack),
		.PIN_RAW_LOW(pin_raw_low), .PIN_RAW_HIGH(pin_raw_high),
		.CONV_START(conv_start), .CONV_ENABLE(en), .HIGH_SPEED_MODE(hsm),
		.CLK_DIV_SEL(div_sel), .INPUT_MUX_OUT(mux_out), .CONV_IRQ_REQ(irq),
		.ANALOG_PIN_BUF_OFF_LOW(buf_low), .PIN_BUF_OFF_HIGH(buf_high),
		.PIN_READ_LOW(read_low), .PIN_READ_HIGH(read_high));
	conv_core_model conv_core_model_inst (.clk(clock), .start(conv_start),
		.slow(slow), .done(conv_done), .result(conv_result), .last_res(res));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock)
		if (conv_start === 1'b1)
			n_starts++;
	function automatic logic [7:0] exp_hi(logic [9:0] v, logic la);
		return la ? v[9:2] : {6'h00, v[9:8]};
	endfunction : exp_hi
	function automatic logic [7:0] exp_lo(logic [9:0] v, logic la);
		return la ? {v[1:0], 6'h00} : v[7:0];
	endfunction : exp_lo
	function automatic int fidx(logic [3:0] c);
		return c < 8 ? c - 1 : (c < 13 ? c - 4 : 0);
	endfunction : fidx
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge clock);
			k++;
		end
		`CHK(k < 20, 1'b1)
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task rdc(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, {24'h0, e})
	endtask : rdc
	task conv(input logic la);
		int k;
		k = 0;
		apb(1'b1, OFS_INPUT_MUX, {26'h0, la, 5'h0});
		slow <= 1'($random(seed));
		apb(1'b1, OFS_CONV_CTRL_A, 32'hc0);
		while (conv_done !== 1'b1 && k < 100)
		begin
			@(posedge clock);
			k++;
		end
		`CHK(k < 100, 1'b1)
		repeat (2) @(posedge clock);
	endtask : conv
	task trig(input logic [3:0] c, input logic au, input int np, input int ex);
		int n0;
		apb(1'b1, OFS_CONV_CTRL_B, {28'h0, c});
		apb(1'b1, OFS_CONV_CTRL_A, au ? 32'ha0 : 32'h80);
		n0 = n_starts;
		repeat (np)
		begin
			if (c inside {[8:10]})
				sync_evt[c - 8] <= 1'b1;
			else
				trig_flags[fidx(c)] <= 1'b1;
			@(posedge clock);
			sync_evt <= 3'h0;
			repeat (3) @(posedge clock);
			trig_flags <= 9'h000;
			@(posedge clock);
		end
		repeat (50) @(posedge clock);
		`CHK(n_starts - n0, ex)
	endtask : trig
	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		{rstn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
		{trig_flags, sync_evt, amp_clk_evt, irq_ack} = '0;
		{pin_raw_low, pin_raw_high} = '0;
		pstrb = 4'hf;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		rdc(OFS_CONV_CTRL_B, 8'h00);
		rdc(OFS_RESULT_LOW, 8'h00);
		rdc(OFS_RESULT_HIGH, 8'h00);
		rdc(OFS_PIN_DIS_0, 8'h00);
		rdc(OFS_PIN_DIS_1, 8'h00);
		apb(1'b0, 8'h1c, 32'h0);
		`CHK(rerr, 1'b1)
		apb(1'b1, OFS_CONV_CTRL_B, 32'h80);
		`CHK(hsm, 1'b1)
		apb(1'b1, OFS_CONV_CTRL_B, 32'h00);
		`CHK(hsm, 1'b0)
		$display("test registers done");
		repeat (8)
		begin
			d0 = 8'($random(seed));
			d1 = 6'($random(seed));
			apb(1'b1, OFS_PIN_DIS_0, {24'h0, d0});
			apb(1'b1, OFS_PIN_DIS_1, {26'h0, d1});
			pin_raw_low <= 8'($random(seed));
			pin_raw_high <= 6'($random(seed));
			repeat (5) @(posedge clock);
			`CHK(buf_low, d0)
			`CHK(buf_high, d1)
			`CHK(read_low, pin_raw_low & ~d0)
			`CHK(read_high, pin_raw_high & ~d1)
		end
		$display("test pins done");
		repeat (4)
		begin
			l = 1'($random(seed));
			conv(l);
			rdc(OFS_RESULT_LOW, exp_lo(res, l));
			rdc(OFS_RESULT_HIGH, exp_hi(res, l));
			apb(1'b1, OFS_INPUT_MUX, {26'h0, ~l, 5'h0});
			rdc(OFS_RESULT_HIGH, exp_hi(res, ~l));
		end
		conv(1'b0);
		d1 = res[5:0];
		d0 = res[9:2];
		rdc(OFS_RESULT_LOW, exp_lo(res, 1'b0));
		conv(1'b0);
		rdc(OFS_RESULT_HIGH, {6'h00, d0[7:6]});
		rdc(OFS_CONV_CTRL_A, 8'h90);
		apb(1'b1, OFS_CONV_CTRL_A, 32'h90);
		rdc(OFS_CONV_CTRL_A, 8'h80);
		$display("test results done");
		slow <= 1'b0;
		for (int c = 1; c < 16; c++)
			trig(4'(c), 1'b1, 1, c < 13 ? 1 : 0);
		trig(4'h1, 1'b0, 1, 0);
		slow <= 1'b1;
		trig(4'h9, 1'b1, 2, 1);
		apb(1'b1, OFS_CONV_CTRL_B, 32'h00);
		n_base = n_starts;
		apb(1'b1, OFS_CONV_CTRL_A, 32'he0);
		repeat (60) @(posedge clock);
		apb(1'b1, OFS_CONV_CTRL_A, 32'h80);
		repeat (40) @(posedge clock);
		`CHK(n_starts - n_base > 1, 1'b1)
		apb(1'b1, OFS_INPUT_MUX, 32'h0b);
		trig(4'h2, 1'b1, 1, 0);
		apb(1'b1, OFS_CONV_CTRL_A, 32'h80);
		$display("test triggers done");
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, OFS_CONV_CTRL_B, 32'h10);
			if (i == 1)
				apb(1'b1, OFS_CONV_CTRL_B, 32'h00);
			n_base = n_starts;
			amp_clk_evt <= 1'b1;
			@(posedge clock);
			amp_clk_evt <= 1'b0;
			repeat (40) @(posedge clock);
			`CHK(n_starts - n_base, i == 0 ? 1 : 0)
			rdc(OFS_CONV_CTRL_B, 8'h00);
		end
		n_base = n_starts;
		d0 = 8'($random(seed)) & 8'h07;
		apb(1'b1, OFS_CONV_CTRL_A, {24'h0, 8'hd8 | d0});
		`CHK(en, 1'b1)
		`CHK(div_sel, d0[2:0])
		`CHK(mux_out, 8'h0b)
		`CHK(irq, 1'b0)
		repeat (40) @(posedge clock);
		`CHK(n_starts - n_base, 1)
		`CHK(irq, 1'b1)
		irq_ack <= 1'b1;
		@(posedge clock);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		rdc(OFS_CONV_CTRL_A, 8'h88 | d0);
		$display("test amplified done");
		print_verdict();
	end
endmodule : test_adc_trigger_and_result_regs
